//--- rtl/rcfg_defines.svh
// Register layout and reset values of the two-wire rate and address block
`ifndef RCFG_DEFINES_SVH
`define RCFG_DEFINES_SVH

`define RCFG_OSA_RESET 8'h00
`define RCFG_BRD_RESET 8'h00
`define RCFG_OSA_ADDR_MSB 7
`define RCFG_OSA_ADDR_LSB 1
`define RCFG_BRD_MUL_MSB 7
`define RCFG_BRD_MUL_LSB 6
`define RCFG_BRD_CODE_MSB 5
`define RCFG_BRD_CODE_LSB 0
`define RCFG_MUL_X1 2'b00
`define RCFG_MUL_X2 2'b01
`define RCFG_MUL_X4 2'b10
`define RCFG_CNT_W 16

`endif

//--- rtl/rcfg_pkg.sv
// Types shared by the two-wire rate and address block
`default_nettype none
package rcfg_pkg;
  typedef logic [15:0] rcfg_cnt_t;

  typedef struct packed {
    logic [11:0] div;
    logic [9:0] sda;
    logic [10:0] start;
    logic [10:0] stop;
  } rcfg_rate_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_HOLD = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_STOP_LOW = 3'b100,
    ST_STOP_HOLD = 3'b101
  } rcfg_state_e;
endpackage
`default_nettype wire

//--- rtl/rcfg_top.sv
// Two-wire bus rate, hold timing and own address configuration with bit timer
//
// Contract
// - Own 7-bit address lives in bits 7..1; used for 7-bit and 10-bit low bits.
// - Multiplier field bits 7..6: 00 x1, 01 x2, 10 x4, 11 reserved.
// - Rate code bits 5..0 selects divider and the three hold counts.
// - Serial clock rate is bus clock over multiplier times divider.
// - SDA changes after SCL falls by SDA hold times multiplier cycles.
// - Start keeps SCL high after SDA falls for start hold times multiplier.
// - Stop releases SDA after SCL rises by stop hold times multiplier.
// - Codes 00..1F map through the fixed divider and hold table.
// - Codes 20..3F continue the same table up to divider 3840.
`include "rcfg_defines.svh"
`default_nettype none
module rcfg_top
  import rcfg_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_OSA_WR,
  input wire logic I_BRD_WR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_OSA_RDATA,
  output logic [7:0] O_BRD_RDATA,
  output logic [6:0] O_OWN_ADDR,
  input wire logic I_START,
  input wire logic I_STOP,
  input wire logic I_TX_BIT,
  output logic O_BUSY,
  output logic O_BIT_DONE,
  output logic O_RX_BIT,
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE
);

  logic [7:0] osa_q;
  logic [7:0] brd_q;
  rcfg_state_e state_q;
  rcfg_cnt_t cnt_q;
  logic stop_pend_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic done_q;
  logic rx_q;
  rcfg_rate_s rate;
  rcfg_cnt_t period;
  rcfg_cnt_t low_len;
  rcfg_cnt_t high_len;
  rcfg_cnt_t sda_len;
  rcfg_cnt_t start_len;
  rcfg_cnt_t stop_len;

  function automatic rcfg_rate_s rate_lookup(input logic [5:0] code);
    rcfg_rate_s t;
    t = '{12'd20, 10'd7, 11'd6, 11'd11};
    unique case (code)
      6'h00: t = '{12'd20, 10'd7, 11'd6, 11'd11};
      6'h01: t = '{12'd22, 10'd7, 11'd7, 11'd12};
      6'h02: t = '{12'd24, 10'd8, 11'd8, 11'd13};
      6'h03: t = '{12'd26, 10'd8, 11'd9, 11'd14};
      6'h04: t = '{12'd28, 10'd9, 11'd10, 11'd15};
      6'h05: t = '{12'd30, 10'd9, 11'd11, 11'd16};
      6'h06: t = '{12'd34, 10'd10, 11'd13, 11'd18};
      6'h07: t = '{12'd40, 10'd10, 11'd16, 11'd21};
      6'h08: t = '{12'd28, 10'd7, 11'd10, 11'd15};
      6'h09: t = '{12'd32, 10'd7, 11'd12, 11'd17};
      6'h0A: t = '{12'd36, 10'd9, 11'd14, 11'd19};
      6'h0B: t = '{12'd40, 10'd9, 11'd16, 11'd21};
      6'h0C: t = '{12'd44, 10'd11, 11'd18, 11'd23};
      6'h0D: t = '{12'd48, 10'd11, 11'd20, 11'd25};
      6'h0E: t = '{12'd56, 10'd13, 11'd24, 11'd29};
      6'h0F: t = '{12'd68, 10'd13, 11'd30, 11'd35};
      6'h10: t = '{12'd48, 10'd9, 11'd18, 11'd25};
      6'h11: t = '{12'd56, 10'd9, 11'd22, 11'd29};
      6'h12: t = '{12'd64, 10'd13, 11'd26, 11'd33};
      6'h13: t = '{12'd72, 10'd13, 11'd30, 11'd37};
      6'h14: t = '{12'd80, 10'd17, 11'd34, 11'd41};
      6'h15: t = '{12'd88, 10'd17, 11'd38, 11'd45};
      6'h16: t = '{12'd104, 10'd21, 11'd46, 11'd53};
      6'h17: t = '{12'd128, 10'd21, 11'd58, 11'd65};
      6'h18: t = '{12'd80, 10'd9, 11'd38, 11'd41};
      6'h19: t = '{12'd96, 10'd9, 11'd46, 11'd49};
      6'h1A: t = '{12'd112, 10'd17, 11'd54, 11'd57};
      6'h1B: t = '{12'd128, 10'd17, 11'd62, 11'd65};
      6'h1C: t = '{12'd144, 10'd25, 11'd70, 11'd73};
      6'h1D: t = '{12'd160, 10'd25, 11'd78, 11'd81};
      6'h1E: t = '{12'd192, 10'd33, 11'd94, 11'd97};
      6'h1F: t = '{12'd240, 10'd33, 11'd118, 11'd121};
      6'h20: t = '{12'd160, 10'd17, 11'd78, 11'd81};
      6'h21: t = '{12'd192, 10'd17, 11'd94, 11'd97};
      6'h22: t = '{12'd224, 10'd33, 11'd110, 11'd113};
      6'h23: t = '{12'd256, 10'd33, 11'd126, 11'd129};
      6'h24: t = '{12'd288, 10'd49, 11'd142, 11'd145};
      6'h25: t = '{12'd320, 10'd49, 11'd158, 11'd161};
      6'h26: t = '{12'd384, 10'd65, 11'd190, 11'd193};
      6'h27: t = '{12'd480, 10'd65, 11'd238, 11'd241};
      6'h28: t = '{12'd320, 10'd33, 11'd158, 11'd161};
      6'h29: t = '{12'd384, 10'd33, 11'd190, 11'd193};
      6'h2A: t = '{12'd448, 10'd65, 11'd222, 11'd225};
      6'h2B: t = '{12'd512, 10'd65, 11'd254, 11'd257};
      6'h2C: t = '{12'd576, 10'd97, 11'd286, 11'd289};
      6'h2D: t = '{12'd640, 10'd97, 11'd318, 11'd321};
      6'h2E: t = '{12'd768, 10'd129, 11'd382, 11'd385};
      6'h2F: t = '{12'd960, 10'd129, 11'd478, 11'd481};
      6'h30: t = '{12'd640, 10'd65, 11'd318, 11'd321};
      6'h31: t = '{12'd768, 10'd65, 11'd382, 11'd385};
      6'h32: t = '{12'd896, 10'd129, 11'd446, 11'd449};
      6'h33: t = '{12'd1024, 10'd129, 11'd510, 11'd513};
      6'h34: t = '{12'd1152, 10'd193, 11'd574, 11'd577};
      6'h35: t = '{12'd1280, 10'd193, 11'd638, 11'd641};
      6'h36: t = '{12'd1536, 10'd257, 11'd766, 11'd769};
      6'h37: t = '{12'd1920, 10'd257, 11'd958, 11'd961};
      6'h38: t = '{12'd1280, 10'd129, 11'd638, 11'd641};
      6'h39: t = '{12'd1536, 10'd129, 11'd766, 11'd769};
      6'h3A: t = '{12'd1792, 10'd257, 11'd894, 11'd897};
      6'h3B: t = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
      6'h3C: t = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
      6'h3D: t = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
      6'h3E: t = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
      6'h3F: t = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
    endcase
    return t;
  endfunction

  // multiplier decode; reserved code runs as x1 so counts stay bounded
  function automatic rcfg_cnt_t scale(input rcfg_cnt_t v, input logic [1:0] m);
    rcfg_cnt_t r;
    r = v;
    unique case (m)
      `RCFG_MUL_X2: r = rcfg_cnt_t'(v << 1);
      `RCFG_MUL_X4: r = rcfg_cnt_t'(v << 2);
      default: r = v;
    endcase
    return r;
  endfunction

  always_comb begin
    rate = rate_lookup(brd_q[`RCFG_BRD_CODE_MSB:`RCFG_BRD_CODE_LSB]);
    period = scale(rcfg_cnt_t'(rate.div), brd_q[`RCFG_BRD_MUL_MSB:`RCFG_BRD_MUL_LSB]);
    low_len = period >> 1;
    high_len = period - low_len;
    sda_len = scale(rcfg_cnt_t'(rate.sda), brd_q[`RCFG_BRD_MUL_MSB:`RCFG_BRD_MUL_LSB]);
    start_len = scale(rcfg_cnt_t'(rate.start), brd_q[`RCFG_BRD_MUL_MSB:`RCFG_BRD_MUL_LSB]);
    stop_len = scale(rcfg_cnt_t'(rate.stop), brd_q[`RCFG_BRD_MUL_MSB:`RCFG_BRD_MUL_LSB]);
  end

  // own address, bit 0 reads zero
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      osa_q <= `RCFG_OSA_RESET;
    end else if (I_OSA_WR) begin
      osa_q <= {I_WDATA[`RCFG_OSA_ADDR_MSB:`RCFG_OSA_ADDR_LSB], 1'b0};
    end
  end

  // Rate changes mid-frame take effect at once, in the compares of the current phase
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      brd_q <= `RCFG_BRD_RESET;
    end else if (I_BRD_WR) begin
      brd_q <= I_WDATA;
    end
  end

  // Stop request waits for the current bit to finish; a new request wins over the clear
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      stop_pend_q <= 1'b0;
    end else if (I_STOP && state_q inside {ST_START_HOLD, ST_LOW, ST_HIGH}) begin
      stop_pend_q <= 1'b1;
    end else if (state_q == ST_HIGH && cnt_q + 16'h0001 >= high_len) begin
      stop_pend_q <= 1'b0;
    end else if (state_q == ST_STOP_LOW) begin
      // A request taken in the last high cycle must not leak into the next frame
      stop_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      cnt_q <= cnt_q + 16'h0001;
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 16'h0000;
          if (I_START) begin
            sda_oe_q <= 1'b1;
            state_q <= ST_START_HOLD;
          end
        end
        // SCL held high after SDA falls
        ST_START_HOLD: begin
          if (cnt_q + 16'h0001 >= start_len) begin
            scl_oe_q <= 1'b1;
            cnt_q <= 16'h0000;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_q + 16'h0001 == sda_len) begin
            sda_oe_q <= ~I_TX_BIT;
          end
          if (cnt_q + 16'h0001 >= low_len) begin
            scl_oe_q <= 1'b0;
            cnt_q <= 16'h0000;
            state_q <= ST_HIGH;
          end
        end
        // bit period is multiplier times divider
        ST_HIGH: begin
          if (cnt_q + 16'h0001 >= high_len) begin
            scl_oe_q <= 1'b1;
            cnt_q <= 16'h0000;
            done_q <= 1'b1;
            rx_q <= I_SDA;
            state_q <= (stop_pend_q || I_STOP) ? ST_STOP_LOW : ST_LOW;
          end
        end
        ST_STOP_LOW: begin
          if (cnt_q + 16'h0001 == sda_len) begin
            sda_oe_q <= 1'b1;
          end
          if (cnt_q + 16'h0001 >= low_len) begin
            scl_oe_q <= 1'b0;
            cnt_q <= 16'h0000;
            state_q <= ST_STOP_HOLD;
          end
        end
        ST_STOP_HOLD: begin
          if (cnt_q + 16'h0001 >= stop_len) begin
            sda_oe_q <= 1'b0;
            cnt_q <= 16'h0000;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          scl_oe_q <= 1'b0;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign O_OSA_RDATA = osa_q;
  assign O_BRD_RDATA = brd_q;
  assign O_OWN_ADDR = osa_q[`RCFG_OSA_ADDR_MSB:`RCFG_OSA_ADDR_LSB];
  assign O_BUSY = (state_q != ST_IDLE);
  assign O_BIT_DONE = done_q;
  assign O_RX_BIT = rx_q;
  // Open drain: only ever pull low
  assign O_SCL = 1'b0;
  assign O_SCL_OE = scl_oe_q;
  assign O_SDA = 1'b0;
  assign O_SDA_OE = sda_oe_q;

endmodule
`default_nettype wire

//--- verification/rcfg_properties.sv
// Port checker for the rate and address block
`default_nettype none
module rcfg_properties (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_OSA_WR,
  input wire logic I_BRD_WR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_START,
  input wire logic [7:0] O_OSA_RDATA,
  input wire logic [7:0] O_BRD_RDATA,
  input wire logic [6:0] O_OWN_ADDR,
  input wire logic O_BUSY,
  input wire logic O_BIT_DONE,
  input wire logic O_SCL_OE,
  input wire logic O_SDA_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // Code 00 at x1: six cycles high after the start edge
  sequence s_start_hold;
    !O_SCL_OE [*6] ##1 O_SCL_OE;
  endsequence
  a_osa_write: assert property (
    I_OSA_WR |=> O_OSA_RDATA == {$past(I_WDATA[7:1]), 1'b0} && O_OWN_ADDR == $past(I_WDATA[7:1]))
    else $error("own address write mismatch");
  a_brd_write: assert property (
    I_BRD_WR |=> O_BRD_RDATA == $past(I_WDATA))
    else $error("divider write mismatch");
  a_start_take: assert property (
    I_START && !O_BUSY |=> O_BUSY && O_SDA_OE && !O_SCL_OE)
    else $error("start not taken");
  a_start_hold: assert property (
    I_START && !O_BUSY && O_BRD_RDATA == 8'h00 |=> s_start_hold)
    else $error("start hold wrong");
  a_done_pulse: assert property (
    O_BIT_DONE |=> !O_BIT_DONE)
    else $error("bit done too long");
  a_done_edge: assert property (
    O_BIT_DONE |-> $rose(O_SCL_OE))
    else $error("bit done off the clock edge");
  a_idle_quiet: assert property (
    !O_BUSY |-> !O_SCL_OE && !O_SDA_OE)
    else $error("lines held while idle");
  a_stop_hold: assert property (
    $fell(O_BUSY) && O_BRD_RDATA == 8'h00 |-> $fell(O_SDA_OE) && $past(O_SCL_OE, 12) && !$past(O_SCL_OE, 11))
    else $error("stop hold wrong");
endmodule
`default_nettype wire

//--- verification/rcfg_bus_partner.sv
// Far side of the two-wire bus: pull-ups and an acknowledging receiver
`default_nettype none
module rcfg_bus_partner (
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  input wire logic i_ack_en,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-ups: a released line reads high, never the last value; SDA reads low while the receiver acknowledges
  assign o_scl = !i_scl_oe;
  assign o_sda = !(i_sda_oe || i_ack_en);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the rate and address block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CODE[6] = '{6'h00, 6'h07, 6'h14, 6'h1F, 6'h20, 6'h3F};
  localparam int DIV[6] = '{20, 40, 80, 240, 160, 3840};
  localparam int HSDA[6] = '{7, 10, 17, 33, 17, 513};
  localparam int HSTA[6] = '{6, 16, 34, 118, 78, 1918};
  localparam int HSTP[6] = '{11, 21, 41, 121, 81, 1921};
  logic clk = 0, rst_n = 0, osa_wr = 0, brd_wr = 0, start = 0, stop = 0, tx = 0, ack = 0;
  logic [7:0] wdata = 8'h00, osa_rd, brd_rd;
  logic [6:0] own;
  logic busy, done, rx, scl_oe, sda_oe, scl, sda, scl_o, sda_o, scl_p = 0, sda_p = 0;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  int scl_r[$], scl_f[$], sda_r[$], sda_f[$];
  always #12.5 clk = ~clk;
  rcfg_top DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_OSA_WR(osa_wr), .I_BRD_WR(brd_wr),
    .I_WDATA(wdata), .O_OSA_RDATA(osa_rd), .O_BRD_RDATA(brd_rd), .O_OWN_ADDR(own),
    .I_START(start), .I_STOP(stop), .I_TX_BIT(tx), .O_BUSY(busy), .O_BIT_DONE(done),
    .O_RX_BIT(rx), .I_SCL(scl), .O_SCL(scl_o), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA(sda_o),
    .O_SDA_OE(sda_oe));
  rcfg_bus_partner u_bus (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_ack_en(ack), .o_scl(scl),
    .o_sda(sda));
  function automatic int mulf(input logic [1:0] m);
    return (m == 2'h2) ? 4 : (m == 2'h1) ? 2 : 1;
  endfunction
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %0d, expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic osa, input logic [7:0] d);
    @(posedge clk);
    osa_wr <= osa;
    brd_wr <= !osa;
    wdata <= d;
    @(posedge clk);
    osa_wr <= 1'b0;
    brd_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_done;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1);
  endtask
  // Edge times of the enables; a late sample shifts all alike
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scl_p <= scl_oe;
    sda_p <= sda_oe;
    if (scl_oe && !scl_p) scl_r.push_back(cyc);
    if (!scl_oe && scl_p) scl_f.push_back(cyc);
    if (sda_oe && !sda_p) sda_r.push_back(cyc);
    if (!sda_oe && sda_p) sda_f.push_back(cyc);
    if (cyc > 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    logic [1:0] m;
    logic [7:0] a;
    int f;
    logic b;
    void'($urandom(60));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(brd_rd, 8'h00, "reset value");
    chk({osa_rd, scl_o, sda_o, busy, done, scl_oe, sda_oe}, 14'h0000, "reset idle");
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : (i == 5) ? 2'h1 : 2'($urandom % 3);
      a = 8'($urandom);
      f = mulf(m);
      wr(1'b1, a);
      chk(osa_rd, {a[7:1], 1'b0}, "address readback");
      chk(own, a[7:1], "own address");
      wr(1'b0, {m, 6'(CODE[i])});
      chk(brd_rd, {m, 6'(CODE[i])}, "divider readback");
      scl_r.delete();
      scl_f.delete();
      sda_r.delete();
      sda_f.delete();
      @(posedge clk);
      start <= 1'b1;
      tx <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_done();
      chk(rx, 1'b1, "released bit");
      @(posedge clk);
      ack <= 1'b1;
      stop <= 1'b1;
      b = 1'($urandom);
      tx <= b;
      @(posedge clk);
      stop <= 1'b0;
      wait_done();
      chk(rx, 1'b0, "acknowledged bit");
      @(posedge clk);
      ack <= 1'b0;
      do @(posedge clk); while (busy !== 1'b0);
      repeat (2) @(posedge clk);
      chk(scl_r[0] - sda_r[0], HSTA[i] * f, "start hold");
      chk(scl_r[2] - scl_r[1], DIV[i] * f, "bit period");
      chk(sda_f[0] - scl_r[0], HSDA[i] * f, "data hold");
      chk(sda_f[$] - scl_f[$], HSTP[i] * f, "stop hold");
      if (!b) chk(sda_r[1] - scl_r[1], HSDA[i] * f, "data hold low");
      $display("Test %0d done, code %0h mul %0d", i, CODE[i], m);
    end
    // Reset in mid-frame drops the frame and clears both registers
    wr(1'b0, 8'h00);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk({scl_o, sda_o, busy, scl_oe, sda_oe}, 5'b00111, "open drain drive");
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({osa_rd, brd_rd, busy, done, scl_oe, sda_oe}, 20'h0_0000, "mid-run reset");
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({busy, scl_oe, sda_oe}, 3'b000, "idle after release");
    $display("Test reset done");
    summarize();
  end
endmodule
bind rcfg_top rcfg_properties u_props (.I_CLK, .I_RST_N, .I_OSA_WR, .I_BRD_WR, .I_WDATA,
  .I_START, .O_OSA_RDATA, .O_BRD_RDATA, .O_OWN_ADDR, .O_BUSY, .O_BIT_DONE, .O_SCL_OE,
  .O_SDA_OE);
`default_nettype wire
